// ### verilog/slqc_top.sv
// serial link quick configuration register bank with ahb-lite access
//
// Behaviour
// [RULE1] quick register clears itself after every write; reads always return zero
// [RULE2] quick register controls nothing directly; it only rewrites link fields
// [RULE3] software writes the quick code first, then any individual overrides
// [RULE4] code zero leaves every link field unchanged
// [RULE5] code 02 loads mode 0, lanes 1, format a 0b, format b 0f
// [RULE6] code 04 loads mode 0, lanes 3, format a 0b, format b 0f
// [RULE7] code 06 loads mode 0, lanes 5, both formats 0b
// [RULE8] code 08 loads mode 0, lanes 7, format a 0b, format b 0f
// [RULE9] code 48 loads mode 4, lanes 7, both formats 0f
// [RULE10] code 81 loads mode 8, lanes 0, both formats 0f
// [RULE11] code 82 loads mode 8, lanes 1, both formats 0f
// [RULE12] code 91 loads mode 9, lanes 0, both formats 0f
// [RULE13] any undefined code leaves every link field unchanged
// [RULE14] reserved codes 01, 42, 44 load no preset; the code leaves the link fields and status code but sets the status ignore bit
// [RULE15] a valid code updates all four fields together with the quick clear
`timescale 1ns/1ps
`include "slqc_map.svh"

module slqc_top #(
    parameter int DATA_W = 32
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [DATA_W-1:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [DATA_W-1:0] hrdata,
    // link configuration fields
    output slqc_pkg::slqc_mode_t cfg_mode,
    output slqc_pkg::slqc_five_t cfg_lanes,
    output slqc_pkg::slqc_five_t cfg_fmt_a,
    output slqc_pkg::slqc_five_t cfg_fmt_b
);
    // ------------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------------
    if (DATA_W != 32) begin : g_bad_width
        $error("slqc_top serves a 32-bit data bus only");
    end

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    slqc_pkg::slqc_regs_s r;
    slqc_pkg::slqc_regs_s next_r;
    logic wr_en;
    slqc_pkg::slqc_idx_t wr_idx;
    logic rd_en;
    slqc_pkg::slqc_idx_t rd_idx;
    slqc_pkg::slqc_code_t q_code;
    logic q_wr;
    logic pre_hit;
    slqc_pkg::slqc_mode_t pre_mode;
    slqc_pkg::slqc_five_t pre_lanes;
    slqc_pkg::slqc_five_t pre_fmt_a;
    slqc_pkg::slqc_five_t pre_fmt_b;

    // ------------------------------------------------------------------
    // read word builder
    // ------------------------------------------------------------------
    // narrow fields sit in the low bits, the rest read as zero
    function automatic logic [31:0] read_word(input slqc_pkg::slqc_regs_s v,
                                              input slqc_pkg::slqc_idx_t idx);
        logic [31:0] w;
        w = `SLQC_WORD_ZERO;
        case (idx)
            // [RULE1] quick reads zero
            `SLQC_IDX_QUICK: w[`SLQC_CODE_MSB:0] = `SLQC_QUICK_RST;
            `SLQC_IDX_MODE: w[`SLQC_MODE_MSB:0] = v.mode;
            `SLQC_IDX_LANES: w[`SLQC_FIVE_MSB:0] = v.lanes;
            `SLQC_IDX_FMT_A: w[`SLQC_FIVE_MSB:0] = v.fmt_a;
            `SLQC_IDX_FMT_B: w[`SLQC_FIVE_MSB:0] = v.fmt_b;
            `SLQC_IDX_STATUS: begin
                w[`SLQC_CODE_MSB:0] = v.last_code;
                w[`SLQC_ST_IGN_BIT] = v.last_ign;
            end
            default: w = `SLQC_WORD_ZERO;
        endcase
        return w;
    endfunction : read_word

    // ------------------------------------------------------------------
    // bus front and preset decoder
    // ------------------------------------------------------------------
    slqc_ahb_front u_front (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .wr_en(wr_en),
        .wr_idx(wr_idx),
        .rd_en(rd_en),
        .rd_idx(rd_idx)
    );

    // write data of the quick register is decoded in the data phase
    assign q_code = hwdata[`SLQC_CODE_MSB:0];
    assign q_wr = wr_en && (wr_idx == `SLQC_IDX_QUICK);

    slqc_preset_dec u_dec (
        .code(q_code),
        .hit(pre_hit),
        .mode(pre_mode),
        .lanes(pre_lanes),
        .fmt_a(pre_fmt_a),
        .fmt_b(pre_fmt_b)
    );

    // ------------------------------------------------------------------
    // register file next state
    // ------------------------------------------------------------------
    // writes land first so a read right behind a write sees the new value
    always_comb begin
        next_r = r;
        if (wr_en) begin
            case (wr_idx)
                `SLQC_IDX_QUICK: begin
                    next_r.last_ign = !pre_hit && (q_code != `SLQC_CODE_NONE);
                    // [RULE15] all fields in one update
                    if (pre_hit) begin
                        next_r.mode = pre_mode;
                        next_r.lanes = pre_lanes;
                        next_r.fmt_a = pre_fmt_a;
                        next_r.fmt_b = pre_fmt_b;
                        next_r.last_code = q_code;
                    end
                end
                // [RULE3] individual overrides after preset
                `SLQC_IDX_MODE: next_r.mode = hwdata[`SLQC_MODE_MSB:0];
                `SLQC_IDX_LANES: next_r.lanes = hwdata[`SLQC_FIVE_MSB:0];
                `SLQC_IDX_FMT_A: next_r.fmt_a = hwdata[`SLQC_FIVE_MSB:0];
                `SLQC_IDX_FMT_B: next_r.fmt_b = hwdata[`SLQC_FIVE_MSB:0];
                default: ;
            endcase
        end
        if (rd_en) begin
            next_r.hrdata = read_word(next_r, rd_idx);
        end
    end

    // ------------------------------------------------------------------
    // register file state
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r.mode <= `SLQC_MODE_RST;
            r.lanes <= `SLQC_LANES_RST;
            r.fmt_a <= `SLQC_FMT_RST;
            r.fmt_b <= `SLQC_FMT_RST;
            r.last_code <= `SLQC_QUICK_RST;
            r.last_ign <= 1'b0;
            r.hrdata <= `SLQC_WORD_ZERO;
        end else begin
            r <= next_r;
        end
    end

    // [RULE2] fields drive the link, quick register does not
    assign cfg_mode = r.mode;
    assign cfg_lanes = r.lanes;
    assign cfg_fmt_a = r.fmt_a;
    assign cfg_fmt_b = r.fmt_b;
    assign hrdata = r.hrdata;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    AST_QUICK_ZERO: assert property ( // [RULE1]
        (rd_en && rd_idx == `SLQC_IDX_QUICK) |=> (hrdata == `SLQC_WORD_ZERO)
    ) else $error("quick register read back nonzero");

    AST_NO_DIRECT: assert property ( // [RULE2]
        !wr_en |=> ($stable(cfg_mode) && $stable(cfg_lanes)
                    && $stable(cfg_fmt_a) && $stable(cfg_fmt_b))
    ) else $error("link field changed without a write");

    AST_CODE_NONE: assert property ( // [RULE4]
        (q_wr && q_code == `SLQC_CODE_NONE) |=> ($stable(cfg_mode) && $stable(cfg_lanes)
                    && $stable(cfg_fmt_a) && $stable(cfg_fmt_b))
    ) else $error("code zero changed the link fields");

    AST_GEN2: assert property ( // [RULE5]
        (q_wr && q_code == `SLQC_CODE_GEN2) |=> (cfg_mode == `SLQC_MODE_GEN
            && cfg_lanes == `SLQC_LANES_2 && cfg_fmt_a == `SLQC_FMT_B
            && cfg_fmt_b == `SLQC_FMT_F)
    ) else $error("two lane preset wrong");

    AST_GEN4: assert property ( // [RULE6]
        (q_wr && q_code == `SLQC_CODE_GEN4) |=> (cfg_mode == `SLQC_MODE_GEN
            && cfg_lanes == `SLQC_LANES_4 && cfg_fmt_a == `SLQC_FMT_B
            && cfg_fmt_b == `SLQC_FMT_F)
    ) else $error("four lane preset wrong");

    AST_GEN6: assert property ( // [RULE7]
        (q_wr && q_code == `SLQC_CODE_GEN6) |=> (cfg_mode == `SLQC_MODE_GEN
            && cfg_lanes == `SLQC_LANES_6 && cfg_fmt_a == `SLQC_FMT_B
            && cfg_fmt_b == `SLQC_FMT_B)
    ) else $error("six lane preset wrong");

    AST_GEN8: assert property ( // [RULE8]
        (q_wr && q_code == `SLQC_CODE_GEN8) |=> (cfg_mode == `SLQC_MODE_GEN
            && cfg_lanes == `SLQC_LANES_8 && cfg_fmt_a == `SLQC_FMT_B
            && cfg_fmt_b == `SLQC_FMT_F)
    ) else $error("eight lane preset wrong");

    AST_DSR8: assert property ( // [RULE9]
        (q_wr && q_code == `SLQC_CODE_DSR8) |=> (cfg_mode == `SLQC_MODE_DSR
            && cfg_lanes == `SLQC_LANES_8 && cfg_fmt_a == `SLQC_FMT_F
            && cfg_fmt_b == `SLQC_FMT_F)
    ) else $error("double rate preset wrong");

    AST_DDCH1: assert property ( // [RULE10]
        (q_wr && q_code == `SLQC_CODE_DDCH1) |=> (cfg_mode == `SLQC_MODE_DDCH
            && cfg_lanes == `SLQC_LANES_1 && cfg_fmt_a == `SLQC_FMT_F
            && cfg_fmt_b == `SLQC_FMT_F)
    ) else $error("wide downconverter one lane preset wrong");

    AST_DDCH2: assert property ( // [RULE11]
        (q_wr && q_code == `SLQC_CODE_DDCH2) |=> (cfg_mode == `SLQC_MODE_DDCH
            && cfg_lanes == `SLQC_LANES_2 && cfg_fmt_a == `SLQC_FMT_F
            && cfg_fmt_b == `SLQC_FMT_F)
    ) else $error("wide downconverter two lane preset wrong");

    AST_DDCL1: assert property ( // [RULE12]
        (q_wr && q_code == `SLQC_CODE_DDCL1) |=> (cfg_mode == `SLQC_MODE_DDCL
            && cfg_lanes == `SLQC_LANES_1 && cfg_fmt_a == `SLQC_FMT_F
            && cfg_fmt_b == `SLQC_FMT_F)
    ) else $error("narrow downconverter preset wrong");

    AST_UNDEF: assert property ( // [RULE13]
        (q_wr && !pre_hit) |=> ($stable(cfg_mode) && $stable(cfg_lanes)
            && $stable(cfg_fmt_a) && $stable(cfg_fmt_b))
    ) else $error("undefined code changed the link fields");

    AST_TOGETHER: assert property ( // [RULE15]
        (q_wr && pre_hit) |=> (cfg_mode == $past(pre_mode)
            && cfg_lanes == $past(pre_lanes) && cfg_fmt_a == $past(pre_fmt_a)
            && cfg_fmt_b == $past(pre_fmt_b))
    ) else $error("preset fields not loaded in one update");

    AST_STATUS: assert property ( // [RULE15]
        (q_wr && pre_hit) ##1 (rd_en && rd_idx == `SLQC_IDX_STATUS)
            |=> (hrdata[`SLQC_CODE_MSB:0] == $past(q_code, 2))
    ) else $error("status does not show the applied code");
endmodule : slqc_top

// ### verilog/slqc_map.svh
// register map, field positions, reset values and preset tables of the quick config block
`ifndef SLQC_MAP_SVH
`define SLQC_MAP_SVH

// register indices; byte address is four times the index
`define SLQC_IDX_QUICK 8'h5e
`define SLQC_IDX_MODE 8'h63
`define SLQC_IDX_LANES 8'h6e
`define SLQC_IDX_FMT_A 8'h72
`define SLQC_IDX_FMT_B 8'h73
`define SLQC_IDX_STATUS 8'h7e
`define SLQC_IDX_NONE 8'hff

// bus address slice holding the index
`define SLQC_ADDR_IDX_MSB 9
`define SLQC_ADDR_IDX_LSB 2
`define SLQC_ADDR_TOP_LSB 10

// field positions
`define SLQC_CODE_MSB 7
`define SLQC_MODE_MSB 3
`define SLQC_FIVE_MSB 4
`define SLQC_ST_IGN_BIT 8

// reset values
`define SLQC_QUICK_RST 8'h00
`define SLQC_MODE_RST 4'h0
`define SLQC_LANES_RST 5'h00
`define SLQC_FMT_RST 5'h00
`define SLQC_WORD_ZERO 32'h0000_0000

// preset codes
`define SLQC_CODE_NONE 8'h00
`define SLQC_CODE_GEN2 8'h02
`define SLQC_CODE_GEN4 8'h04
`define SLQC_CODE_GEN6 8'h06
`define SLQC_CODE_GEN8 8'h08
`define SLQC_CODE_DSR8 8'h48
`define SLQC_CODE_DDCH1 8'h81
`define SLQC_CODE_DDCH2 8'h82
`define SLQC_CODE_DDCL1 8'h91

// preset field values
`define SLQC_MODE_GEN 4'h0
`define SLQC_MODE_DSR 4'h4
`define SLQC_MODE_DDCH 4'h8
`define SLQC_MODE_DDCL 4'h9
`define SLQC_LANES_1 5'h00
`define SLQC_LANES_2 5'h01
`define SLQC_LANES_4 5'h03
`define SLQC_LANES_6 5'h05
`define SLQC_LANES_8 5'h07
`define SLQC_FMT_B 5'h0b
`define SLQC_FMT_F 5'h0f

`endif

// ### verilog/slqc_pkg.sv
// types shared by the quick config block
package slqc_pkg;
    typedef logic [3:0] slqc_mode_t;
    typedef logic [4:0] slqc_five_t;
    typedef logic [7:0] slqc_code_t;
    typedef logic [7:0] slqc_idx_t;

    // bus front state
    typedef struct packed {
        logic hreadyout;
        logic hresp;
        logic wr_pend;
        slqc_idx_t wr_idx;
    } slqc_front_s;

    // register file state
    typedef struct packed {
        slqc_mode_t mode;
        slqc_five_t lanes;
        slqc_five_t fmt_a;
        slqc_five_t fmt_b;
        slqc_code_t last_code;
        logic last_ign;
        logic [31:0] hrdata;
    } slqc_regs_s;
endpackage : slqc_pkg

// ### verilog/slqc_preset_dec.sv
// preset code decoder: code to the four link field values
`timescale 1ns/1ps
`include "slqc_map.svh"

module slqc_preset_dec (
    // code in
    input wire slqc_pkg::slqc_code_t code,
    // decoded preset
    output logic hit,
    output slqc_pkg::slqc_mode_t mode,
    output slqc_pkg::slqc_five_t lanes,
    output slqc_pkg::slqc_five_t fmt_a,
    output slqc_pkg::slqc_five_t fmt_b
);
    // table lookup; reserved and unknown codes give no hit
    always_comb begin
        hit = 1'b1;
        mode = `SLQC_MODE_GEN;
        lanes = `SLQC_LANES_1;
        fmt_a = `SLQC_FMT_F;
        fmt_b = `SLQC_FMT_F;
        case (code)
            // [RULE5] two lane generic
            `SLQC_CODE_GEN2: begin
                lanes = `SLQC_LANES_2;
                fmt_a = `SLQC_FMT_B;
            end
            // [RULE6] four lane generic
            `SLQC_CODE_GEN4: begin
                lanes = `SLQC_LANES_4;
                fmt_a = `SLQC_FMT_B;
            end
            // [RULE7] six lane generic
            `SLQC_CODE_GEN6: begin
                lanes = `SLQC_LANES_6;
                fmt_a = `SLQC_FMT_B;
                fmt_b = `SLQC_FMT_B;
            end
            // [RULE8] eight lane generic
            `SLQC_CODE_GEN8: begin
                lanes = `SLQC_LANES_8;
                fmt_a = `SLQC_FMT_B;
            end
            // [RULE9] double rate eight lanes
            `SLQC_CODE_DSR8: begin
                mode = `SLQC_MODE_DSR;
                lanes = `SLQC_LANES_8;
            end
            // [RULE10] wide downconverter one lane
            `SLQC_CODE_DDCH1: begin
                mode = `SLQC_MODE_DDCH;
            end
            // [RULE11] wide downconverter two lanes
            `SLQC_CODE_DDCH2: begin
                mode = `SLQC_MODE_DDCH;
                lanes = `SLQC_LANES_2;
            end
            // [RULE12] narrow downconverter one lane
            `SLQC_CODE_DDCL1: begin
                mode = `SLQC_MODE_DDCL;
            end
            // [RULE13] undefined codes miss
            default: begin
                hit = 1'b0;
            end
        endcase
    end
endmodule : slqc_preset_dec

// ### verilog/slqc_ahb_front.sv
// ahb-lite slave front: address phase capture, zero wait state
`timescale 1ns/1ps
`include "slqc_map.svh"

module slqc_ahb_front (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite address phase
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    // bus answer
    output logic hreadyout,
    output logic hresp,
    // register side
    output logic wr_en,
    output slqc_pkg::slqc_idx_t wr_idx,
    output logic rd_en,
    output slqc_pkg::slqc_idx_t rd_idx
);
    slqc_pkg::slqc_front_s s;
    slqc_pkg::slqc_front_s next_s;
    logic take;
    logic mapped;
    slqc_pkg::slqc_idx_t a_idx;

    // address decode; upper address bits must be zero
    always_comb begin
        take = hsel && htrans[1] && hready;
        mapped = (haddr[31:`SLQC_ADDR_TOP_LSB] == 22'h000000);
        a_idx = mapped ? haddr[`SLQC_ADDR_IDX_MSB:`SLQC_ADDR_IDX_LSB] : `SLQC_IDX_NONE;
        next_s = s;
        next_s.hreadyout = 1'b1;
        next_s.hresp = 1'b0;
        next_s.wr_pend = take && hwrite;
        if (take) begin
            next_s.wr_idx = a_idx;
        end
    end

    // state register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '{hreadyout: 1'b1, hresp: 1'b0, wr_pend: 1'b0, wr_idx: `SLQC_IDX_NONE};
        end else begin
            s <= next_s;
        end
    end

    assign hreadyout = s.hreadyout;
    assign hresp = s.hresp;
    assign wr_en = s.wr_pend;
    assign wr_idx = s.wr_idx;
    assign rd_en = take && !hwrite;
    assign rd_idx = a_idx;
endmodule : slqc_ahb_front

// ### verif/slqc_tb.sv
// self-checking bench for the quick config register bank
`timescale 1ns/1ps
`include "slqc_map.svh"

module testbench;
    // ------------------------------------------------------------
    // bench signals
    // ------------------------------------------------------------
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hready;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    slqc_pkg::slqc_mode_t cfg_mode;
    slqc_pkg::slqc_five_t cfg_lanes;
    slqc_pkg::slqc_five_t cfg_fmt_a;
    slqc_pkg::slqc_five_t cfg_fmt_b;
    logic [18:0] mid;
    logic [18:0] prev;
    logic [31:0] rd;
    int mismatches = 0;
    int tests_run = 0;
    // preset table: code, mode, lanes, format a, format b
    logic [26:0] presets [8] = '{
        {8'h02, 4'h0, 5'h01, 5'h0b, 5'h0f}, {8'h04, 4'h0, 5'h03, 5'h0b, 5'h0f},
        {8'h06, 4'h0, 5'h05, 5'h0b, 5'h0b}, {8'h08, 4'h0, 5'h07, 5'h0b, 5'h0f},
        {8'h48, 4'h4, 5'h07, 5'h0f, 5'h0f}, {8'h81, 4'h8, 5'h00, 5'h0f, 5'h0f},
        {8'h82, 4'h8, 5'h01, 5'h0f, 5'h0f}, {8'h91, 4'h9, 5'h00, 5'h0f, 5'h0f}};
    // codes that must not touch the link fields, zero first
    logic [7:0] idle_codes [6] = '{8'h00, 8'h01, 8'h42, 8'h44, 8'h03, 8'hff};

    // single slave: its ready is the bus ready
    assign hready = hreadyout;

    // 125 MHz clock
    always #4 hclk = ~hclk;

    slqc_top #(.DATA_W(32)) dut_u (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .hwdata(hwdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .cfg_mode(cfg_mode),
        .cfg_lanes(cfg_lanes),
        .cfg_fmt_a(cfg_fmt_a),
        .cfg_fmt_b(cfg_fmt_b)
    );

    // ------------------------------------------------------------
    // report and compare
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // ------------------------------------------------------------
    // ahb-lite master
    // ------------------------------------------------------------
    function automatic logic [31:0] ra(input logic [7:0] idx);
        return {22'h0, idx, 2'b00};
    endfunction : ra

    // wait for ready high at a rising edge, bounded
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin
            mismatches++;
            print_verdict();
        end
    endtask : wait_ready

    // one word transfer; link fields are sampled mid data phase
    task automatic bus_xfer(input logic [31:0] addr, input logic wr, input logic [31:0] data,
                            output logic [31:0] rdata);
        haddr <= addr;
        hwrite <= wr;
        htrans <= 2'b10;
        hsel <= 1'b1;
        wait_ready();
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= data;
        #1 mid = {cfg_mode, cfg_lanes, cfg_fmt_a, cfg_fmt_b};
        wait_ready();
        rdata = hrdata;
    endtask : bus_xfer

    task automatic bus_write(input logic [31:0] addr, input logic [31:0] data);
        logic [31:0] dummy;
        bus_xfer(addr, 1'b1, data, dummy);
    endtask : bus_write

    task automatic bus_read(input logic [31:0] addr, output logic [31:0] data);
        bus_xfer(addr, 1'b0, 32'h0000_0000, data);
    endtask : bus_read

    // compare the link fields once settled, then realign to an edge
    task automatic check_cfg(input logic [18:0] exp);
        #1 check({13'h0, cfg_mode, cfg_lanes, cfg_fmt_a, cfg_fmt_b}, {13'h0, exp});
        @(posedge hclk);
    endtask : check_cfg

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        check_cfg(19'h0);
        bus_read(ra(`SLQC_IDX_QUICK), rd);
        check(rd, 32'h0000_0000);
        prev = 19'h0;
        for (int i = 0; i < 8; i++) begin
            bus_write(ra(`SLQC_IDX_QUICK), {24'h0, presets[i][26:19]});
            check({13'h0, mid}, {13'h0, prev});
            check_cfg(presets[i][18:0]);
            bus_read(ra(`SLQC_IDX_QUICK), rd);
            check(rd, 32'h0000_0000);
            bus_read(ra(`SLQC_IDX_STATUS), rd);
            check(rd, {24'h0, presets[i][26:19]});
            bus_read(ra(`SLQC_IDX_LANES), rd);
            check(rd, {27'h0, presets[i][14:10]});
            prev = presets[i][18:0];
        end
        for (int j = 0; j < 6; j++) begin
            bus_write(ra(`SLQC_IDX_QUICK), {24'h0, idle_codes[j]});
            check_cfg(prev);
            bus_read(ra(`SLQC_IDX_QUICK), rd);
            check(rd, 32'h0000_0000);
        end
        bus_read(ra(`SLQC_IDX_STATUS), rd);
        check({31'h0, rd[8]}, 32'h0000_0001);
        bus_write(ra(`SLQC_IDX_QUICK), 32'h0000_0008);
        bus_write(ra(`SLQC_IDX_LANES), 32'hffff_fff3);
        check_cfg({4'h0, 5'h13, 5'h0b, 5'h0f});
        bus_read(ra(`SLQC_IDX_LANES), rd);
        check(rd, 32'h0000_0013);
        bus_write(ra(`SLQC_IDX_QUICK), 32'h0000_0000);
        check_cfg({4'h0, 5'h13, 5'h0b, 5'h0f});
        // neighbour and aliased addresses do nothing
        bus_write(ra(8'h5f), 32'h0000_0002);
        bus_write(32'h0000_0400 | ra(`SLQC_IDX_QUICK), 32'h0000_0002);
        check_cfg({4'h0, 5'h13, 5'h0b, 5'h0f});
        bus_read(32'h0000_0400 | ra(`SLQC_IDX_LANES), rd);
        check(rd, 32'h0000_0000);
        // mid-run reset, then a preset again
        hresetn <= 1'b0;
        @(posedge hclk);
        check_cfg(19'h0);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus_write(ra(`SLQC_IDX_QUICK), 32'h0000_0006);
        check({13'h0, mid}, 32'h0000_0000);
        check_cfg({4'h0, 5'h05, 5'h0b, 5'h0b});
        bus_read(ra(`SLQC_IDX_QUICK), rd);
        check(rd, 32'h0000_0000);
        print_verdict();
    end
endmodule : testbench
